// ### rtl/ulf_top.sv
/*
 UART line-format control with AXI4-Lite register slave,
 divisor latch, break control, interrupt flags and transmitter.
 Assumes a single 20 MHz clock and a synchronous active-low reset.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ulf_defines.svh"

module ulf_top
(
   input wire logic aclk, // System clock, 20 MHz
   input wire logic aresetn, // Sync reset, active low
   input wire logic [7:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write byte enables
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [7:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   output logic tx_out, // Serial transmit line
   output logic irq // Level interrupt, high active
);
   import ulf_pkg::*;

   // Register index, or an out-of-map marker
   function automatic logic [3:0] reg_sel(input logic [7:0] a);
      case (a)
         `ULF_OFF_DATA: reg_sel = 4'h0;
         `ULF_OFF_IEN: reg_sel = 4'h1;
         `ULF_OFF_ISS: reg_sel = 4'h2;
         `ULF_OFF_LFC: reg_sel = 4'h3;
         `ULF_OFF_EVT: reg_sel = 4'h4;
         default: reg_sel = 4'hF;
      endcase
   endfunction

   ulf_lfc_t lfc_reg;
   logic [7:0] div_lo_reg;
   logic [7:0] div_hi_reg;
   logic [1:0] ien_reg;
   logic [1:0] evt_reg;
   logic [1:0] evt_next;
   logic [15:0] baud_reg;
   logic half_tick;
   logic [7:0] aw_reg;
   logic aw_have;
   logic [31:0] w_reg;
   logic [3:0] ws_reg;
   logic w_have;
   logic wr_go;
   logic [3:0] wsel;
   logic [3:0] rsel;
   logic lane0;
   logic [7:0] thr_reg;
   logic thr_full;
   logic tx_busy;
   logic tx_done;
   logic tx_start;
   logic pend;
   logic [7:0] iss;
   logic [31:0] rd_val;

   // ---------------- AXI4-Lite write path ----------------
   assign s_axi_awready = !aw_have && !s_axi_bvalid;
   assign s_axi_wready = !w_have && !s_axi_bvalid;
   assign wr_go = aw_have && w_have && !s_axi_bvalid;
   assign wsel = reg_sel(aw_reg);
   assign lane0 = wr_go && ws_reg[0];

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have <= 1'b0;
         aw_reg <= 8'h00;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_have <= 1'b1;
         aw_reg <= s_axi_awaddr;
      end
      else if (wr_go)
         aw_have <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_have <= 1'b0;
         w_reg <= 32'h0000_0000;
         ws_reg <= 4'h0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_have <= 1'b1;
         w_reg <= s_axi_wdata;
         ws_reg <= s_axi_wstrb;
      end
      else if (wr_go)
         w_have <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `ULF_RESP_OKAY;
      end
      else if (wr_go)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (wsel == 4'hF) ? `ULF_RESP_SLVERR : `ULF_RESP_OKAY;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // ---------------- Register writes ----------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         lfc_reg <= `ULF_LFC_RST;
      else if (lane0 && wsel == 4'h3)
         lfc_reg <= w_reg[7:0];
   end

   // Divisor latch shares offsets with data and enable
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         {div_hi_reg, div_lo_reg} <= `ULF_DIV_RST;
      end
      else if (lane0 && lfc_reg.dlab)
      begin
         if (wsel == 4'h0)
            div_lo_reg <= w_reg[7:0];
         if (wsel == 4'h1)
            div_hi_reg <= w_reg[7:0];
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ien_reg <= `ULF_EVT_RST;
      else if (lane0 && !lfc_reg.dlab && wsel == 4'h1)
         ien_reg <= w_reg[1:0];
   end

   // One holding byte; a write while it is still full is dropped
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         thr_reg <= 8'h00;
         thr_full <= 1'b0;
      end
      else if (lane0 && !lfc_reg.dlab && wsel == 4'h0 && !thr_full)
      begin
         thr_reg <= w_reg[7:0];
         thr_full <= 1'b1;
      end
      else if (tx_start)
         thr_full <= 1'b0;
   end

   assign tx_start = thr_full && !tx_busy;

   // ---------------- Event flags ----------------
   // Set beats a simultaneous write-one clear
   always_comb
   begin
      evt_next = evt_reg;
      if (lane0 && wsel == 4'h4)
         evt_next = evt_next & ~w_reg[1:0];
      if (tx_done)
         evt_next[`ULF_EVT_SENT] = 1'b1;
      if (lane0 && !lfc_reg.dlab && wsel == 4'h0 && thr_full)
         evt_next[`ULF_EVT_DROP] = 1'b1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         evt_reg <= `ULF_EVT_RST;
      else
         evt_reg <= evt_next;
   end

   assign pend = |(evt_reg & ien_reg);
   assign irq = pend;

   always_comb
   begin
      if (pend)
         iss = `ULF_ISS_TXCODE;
      else
         iss = `ULF_ISS_IDLE;
   end

   // ---------------- Half-bit timing ----------------
   // Divisor counts clocks per half bit, so 1.5 stop bits is exact;
   // zero behaves as one
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         baud_reg <= 16'h0000;
      else if (half_tick)
         baud_reg <= 16'h0000;
      else
         baud_reg <= baud_reg + 16'h0001;
   end

   assign half_tick = (baud_reg + 16'h0001 >= {div_hi_reg, div_lo_reg});

   ulf_tx u_tx
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .half_tick(half_tick),
      .start(tx_start),
      .data(thr_reg),
      .cfg(lfc_reg),
      .tx(tx_out),
      .busy(tx_busy),
      .done(tx_done)
   );

   // ---------------- AXI4-Lite read path ----------------
   assign s_axi_arready = !s_axi_rvalid;
   assign rsel = reg_sel(s_axi_araddr);

   always_comb
   begin
      rd_val = 32'h0000_0000;
      case (rsel)
         4'h0:
            if (lfc_reg.dlab)
               rd_val[7:0] = div_lo_reg;
         4'h1:
            if (lfc_reg.dlab)
               rd_val[7:0] = div_hi_reg;
            else
               rd_val[1:0] = ien_reg;
         4'h2: rd_val[7:0] = iss;
         4'h3: rd_val[7:0] = lfc_reg;
         4'h4: rd_val[7:0] = {tx_busy, thr_full, 4'h0, evt_reg};
         default: rd_val = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `ULF_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_val;
         s_axi_rresp <= (rsel == 4'hF) ? `ULF_RESP_SLVERR : `ULF_RESP_OKAY;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

endmodule
`default_nettype wire

// ### rtl/ulf_defines.svh
/*
 Register offsets, field positions, reset values and timing
 counts of the UART line-format block. Included by package and
 design files by bare name; holds definitions only.
*/
`ifndef ULF_DEFINES_SVH
`define ULF_DEFINES_SVH

`define ULF_OFF_DATA 8'h00
`define ULF_OFF_IEN 8'h04
`define ULF_OFF_ISS 8'h08
`define ULF_OFF_LFC 8'h0C
`define ULF_OFF_EVT 8'h10
`define ULF_LFC_RST 8'h00
`define ULF_DIV_RST 16'h0001
`define ULF_EVT_RST 2'h0
`define ULF_EVT_SENT 0
`define ULF_EVT_DROP 1
`define ULF_ISS_IDLE 8'h01
`define ULF_ISS_TXCODE 8'h02
`define ULF_RESP_OKAY 2'h0
`define ULF_RESP_SLVERR 2'h2
`define ULF_HALVES_BIT 3'h2
`define ULF_HALVES_STOP1 3'h2
`define ULF_HALVES_STOP15 3'h3
`define ULF_HALVES_STOP2 3'h4
`define ULF_WLEN_5 2'h0

`endif

// ### rtl/ulf_pkg.sv
/*
 Types shared by the UART line-format block.
 Assumes ulf_defines.svh sits beside it.
*/
`include "ulf_defines.svh"

package ulf_pkg;

   typedef struct packed {
      logic       dlab;
      logic       brk;
      logic [2:0] par;
      logic       stop;
      logic [1:0] wlen;
   } ulf_lfc_t;

   typedef enum logic [2:0] {
      ULF_IDLE  = 3'b000,
      ULF_START = 3'b001,
      ULF_DATA  = 3'b010,
      ULF_PAR   = 3'b011,
      ULF_STOP  = 3'b100
   } ulf_txst_t;

endpackage

// ### rtl/ulf_tx.sv
/*
 Serial character transmitter of the line-format block.
 Assumes one half_tick pulse per half bit time from the parent.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ulf_defines.svh"

module ulf_tx
(
   input wire logic aclk, // System clock
   input wire logic aresetn, // Sync reset, active low
   input wire logic half_tick, // Half bit time strobe
   input wire logic start, // Load char when idle
   input wire logic [7:0] data, // Character to send
   input wire ulf_pkg::ulf_lfc_t cfg, // Line format
   output logic tx, // Serial output
   output logic busy, // Character in flight
   output logic done // Pulse, char finished
);
   import ulf_pkg::*;

   ulf_txst_t st_reg;
   logic [2:0] hc_reg;
   logic [2:0] bit_reg;
   logic [7:0] sh_reg;
   logic acc_reg;
   logic [2:0] len;
   logic [2:0] nbits;
   logic pbit;
   logic line;
   logic bit_end;

   always_comb
   begin
      nbits = 3'd4 + {1'b0, cfg.wlen};
      if (st_reg != ULF_STOP)
         len = `ULF_HALVES_BIT;
      else if (!cfg.stop)
         len = `ULF_HALVES_STOP1;
      else if (cfg.wlen == `ULF_WLEN_5)
         len = `ULF_HALVES_STOP15;
      else
         len = `ULF_HALVES_STOP2;
      case (cfg.par[2:1])
         2'b00: pbit = ~acc_reg;
         2'b01: pbit = acc_reg;
         2'b10: pbit = 1'b1;
         default: pbit = 1'b0;
      endcase
      case (st_reg)
         ULF_START: line = 1'b0;
         ULF_DATA: line = sh_reg[0];
         ULF_PAR: line = pbit;
         default: line = 1'b1;
      endcase
   end

   assign bit_end = half_tick && (hc_reg + 3'd1 == len);
   assign busy = (st_reg != ULF_IDLE);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_reg <= ULF_IDLE;
         hc_reg <= 3'd0;
         bit_reg <= 3'd0;
         sh_reg <= 8'h00;
         acc_reg <= 1'b0;
         done <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         if (st_reg == ULF_IDLE)
         begin
            hc_reg <= 3'd0;
            if (start)
            begin
               sh_reg <= data;
               acc_reg <= 1'b0;
               bit_reg <= 3'd0;
               st_reg <= ULF_START;
            end
         end
         else if (bit_end)
         begin
            hc_reg <= 3'd0;
            case (st_reg)
               ULF_START: st_reg <= ULF_DATA;
               ULF_DATA:
               begin
                  acc_reg <= acc_reg ^ sh_reg[0];
                  sh_reg <= {1'b0, sh_reg[7:1]};
                  bit_reg <= bit_reg + 3'd1;
                  if (bit_reg == nbits)
                     st_reg <= cfg.par[0] ? ULF_PAR : ULF_STOP;
               end
               ULF_PAR: st_reg <= ULF_STOP;
               default:
               begin
                  st_reg <= ULF_IDLE;
                  done <= 1'b1;
               end
            endcase
         end
         else if (half_tick)
            hc_reg <= hc_reg + 3'd1;
      end
   end

   // Break overrides the line; on release the line goes back to
   // idle-high or the character still in flight
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         tx <= 1'b1;
      else
         tx <= cfg.brk ? 1'b0 : line;
   end

endmodule
`default_nettype wire

// ### bench/ulf_asserts.sv
/*
 Port checker for ulf_top.
 Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ns
`default_nettype none

module ulf_asserts
(
   input wire logic aclk, // Clock
   input wire logic aresetn, // Reset, active low
   input wire logic [7:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // AW valid
   input wire logic s_axi_awready, // AW ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Strobes
   input wire logic s_axi_wvalid, // W valid
   input wire logic s_axi_wready, // W ready
   input wire logic [1:0] s_axi_bresp, // B code
   input wire logic s_axi_bvalid, // B valid
   input wire logic s_axi_bready, // B ready
   input wire logic s_axi_arvalid, // AR valid
   input wire logic s_axi_arready, // AR ready
   input wire logic [31:0] s_axi_rdata, // Read data
   input wire logic s_axi_rvalid, // R valid
   input wire logic s_axi_rready, // R ready
   input wire logic tx_out, // Serial line
   input wire logic irq // Interrupt
);
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence wr_both;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
   endsequence
   sequence brk_wr;
      wr_both ##0 (s_axi_awaddr == 8'h0C && s_axi_wdata[6]);
   endsequence

   a_rst_idle: assert property ($rose(aresetn) |-> tx_out && !irq && !s_axi_bvalid)
      else $error("outputs not idle after reset");
   a_break_low: assert property (brk_wr |-> ##[1:3] !tx_out)
      else $error("break did not pull line low");
   a_wr_lat: assert property (wr_both |=> !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write response timing wrong");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   a_b_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken during response");
   a_rd_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready && s_axi_rdata[31:8] == '0)
      else $error("read channel misbehaves");
endmodule

bind ulf_top ulf_asserts u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
   .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .tx_out(tx_out), .irq(irq));

`default_nettype wire

// ### bench/ulf_rx_model.sv
/*
 Remote serial receiver model.
 Assumes BITC clocks per bit and a format given by the bench.
*/
`timescale 1ns/1ns
`default_nettype none

module ulf_rx_model
#(
   parameter int BITC = 4
)
(
   input wire logic aclk, // Clock
   input wire logic line, // Serial line
   input wire logic [3:0] nbits, // Data bits
   input wire logic par_en, // Parity present
   output logic [7:0] rx_byte, // Last data
   output logic rx_par, // Last parity
   output logic rx_stop, // First stop level
   output int rx_cnt // Frames seen
);
   initial
   begin
      rx_cnt = 0;
      rx_byte = 8'h00;
      rx_par = 1'b0;
      rx_stop = 1'b0;
      forever
      begin
         @(negedge line);
         // Mid-bit sampling
         repeat (BITC / 2) @(posedge aclk);
         rx_byte = 8'h00;
         for (int i = 0; i < nbits; i++)
         begin
            repeat (BITC) @(posedge aclk);
            rx_byte[i] = line;
         end
         if (par_en)
         begin
            repeat (BITC) @(posedge aclk);
            rx_par = line;
         end
         repeat (BITC) @(posedge aclk);
         rx_stop = line;
         rx_cnt++;
      end
   end
endmodule

`default_nettype wire

// ### bench/test_uart_line_format_control.sv
/*
 Self-checking bench for ulf_top.
 Assumes the checker bind and the receiver model.
*/
`timescale 1ns/1ns
`default_nettype none

module test_uart_line_format_control;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, rx_byte;
   logic [31:0] wdata = 32'h0000_0000, rdata, rd;
   logic [3:0] wstrb = 4'hF, nbits = 4'h8;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, tx_out, irq, rx_par, rx_stop;
   logic par_en = 1'b0;
   logic [1:0] bresp, rresp, resp;
   int rx_cnt, error_cnt = 0, compares = 0;

   initial
   begin
      forever #25 aclk = ~aclk;
   end

   ulf_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .tx_out(tx_out), .irq(irq));

   ulf_rx_model #(.BITC(4)) u_rx (.aclk(aclk), .line(tx_out), .nbits(nbits),
      .par_en(par_en), .rx_byte(rx_byte), .rx_par(rx_par), .rx_stop(rx_stop), .rx_cnt(rx_cnt));

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic aw;
      logic w;
      aw = 1'b1;
      w = 1'b1;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h00_0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (aw && awready === 1'b1)
         begin
            aw = 1'b0;
            awvalid <= 1'b0;
         end
         if (w && wready === 1'b1)
         begin
            w = 1'b0;
            wvalid <= 1'b0;
         end
      end while (aw || w);
      do @(posedge aclk); while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
   endtask

   task automatic rdr(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rd = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask

   task automatic send(input logic [7:0] lfc, input logic [7:0] b);
      int c0;
      logic [7:0] m;
      logic p;
      m = b & (8'hFF >> (2'd3 - lfc[1:0]));
      p = (lfc[5:3] == 3'b001) ? ~^m : (lfc[5:3] == 3'b011) ? ^m : (lfc[5:3] == 3'b101);
      wr(8'h0C, lfc);
      nbits = 4'h5 + {2'b00, lfc[1:0]};
      par_en = lfc[3];
      c0 = rx_cnt;
      wr(8'h00, b);
      while (rx_cnt == c0) @(posedge aclk);
      // Let the stop bits and event flag finish
      repeat (40) @(posedge aclk);
      chk("rx data", {24'h00_0000, m}, {24'h00_0000, rx_byte});
      if (lfc[3])
         chk("rx parity", {31'h0, p}, {31'h0, rx_par});
      chk("rx stop", 1, {31'h0, rx_stop});
   endtask

   task automatic t_reset;
      rdr(8'h0C);
      chk("lfc reset", 0, rd);
      rdr(8'h08);
      chk("status reset", 1, rd);
      chk("tx idle", 1, {31'h0, tx_out});
   endtask

   task automatic t_latch;
      wr(8'h0C, 8'h80);
      wr(8'h00, 8'h02);
      wr(8'h04, 8'h00);
      rdr(8'h00);
      chk("divisor low", 2, rd);
      rdr(8'h0C);
      chk("lfc back", 32'h0000_0080, rd);
      wr(8'h0C, 8'h03);
      rdr(8'h00);
      chk("data read", 0, rd);
   endtask

   task automatic t_frames;
      logic [7:0] cf[6] = '{8'h00, 8'h09, 8'h1A, 8'h2F, 8'h3B, 8'h04};
      logic [7:0] by[6] = '{8'h15, 8'h2A, 8'h55, 8'hA5, 8'h3C, 8'hC3};
      for (int i = 0; i < 6; i++)
         send(cf[i], by[i]);
   endtask

   task automatic t_irq;
      // Old sent flags would make the irq quiet check fail and the irq set check trivially true
      wr(8'h10, 8'h03);
      wr(8'h04, 8'h01);
      chk("irq quiet", 0, {31'h0, irq});
      send(8'h03, 8'h81);
      chk("irq set", 1, {31'h0, irq});
      rdr(8'h08);
      chk("status pend", 2, rd);
      wr(8'h04, 8'h00);
      chk("irq masked", 0, {31'h0, irq});
      wr(8'h04, 8'h01);
      wr(8'h10, 8'h01);
      chk("irq clear", 0, {31'h0, irq});
      rdr(8'h08);
      chk("status idle", 1, rd);
   endtask

   task automatic t_break;
      wr(8'h0C, 8'h43);
      repeat (3) @(posedge aclk);
      chk("break low", 0, {31'h0, tx_out});
      repeat (30) @(posedge aclk);
      chk("break held", 0, {31'h0, tx_out});
      wr(8'h0C, 8'h03);
      repeat (3) @(posedge aclk);
      chk("break off", 1, {31'h0, tx_out});
      rdr(8'h20);
      chk("unmapped rresp", 2, {30'h0, resp});
      chk("unmapped rdata", 0, rd);
      wr(8'h20, 8'hFF);
      chk("unmapped bresp", 2, {30'h0, resp});
   endtask

   task automatic complete_run;
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial
   begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset;
      t_latch;
      t_frames;
      t_irq;
      t_break;
      complete_run;
   end

   initial
   begin
      // Run needs about 750 cycles
      repeat (20000) @(posedge aclk);
      error_cnt++;
      complete_run;
   end
endmodule

`default_nettype wire
